// ==== rtl/eeprom_defs.svh ====
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH
// How it works
// RULE_01 - three mode lines pick one of seven modes; one code is unused
// RULE_02 - standby keeps address and data registers and floats the data pin
// RULE_03 - erase clears the addressed word so every bit reads low
// RULE_04 - accept-address shifts one pin bit into the address registers per clock pulse
// RULE_05 - address is two one-of-ten digits, tens then units, decoded to a word
// RULE_06 - array holds one hundred words of fourteen bits; data register is fourteen bits
// RULE_07 - read copies the addressed word into the data register, pin stays floating
// RULE_08 - shift-out enables the driver and shifts data register out per clock pulse
// RULE_09 - write programs the data register into the addressed word
// RULE_10 - accept-data shifts pin bits into the data register, address untouched
// RULE_11 - pin is input in accept modes, driven only in shift-out, else floating
// RULE_12 - controller supplies a 14 kHz clock, 11.2 to 16.8 kHz, in every mode but standby
// RULE_13 - controller may park the clock high only during standby
// RULE_14 - controller holds erase or write for 16 to 24 ms per word
// RULE_15 - controller erases a word before writing it
// RULE_16 - serial transfers go least significant bit first, full register width each
// RULE_17 - the unused mode code behaves exactly like standby

// ---------------------------------------------------------------
// mode codes on {mode_select_a, mode_select_b, mode_select_c}
// ---------------------------------------------------------------
`define MODE_CODE_STANDBY 3'h7
`define MODE_CODE_UNUSED 3'h6
`define MODE_CODE_ERASE 3'h5
`define MODE_CODE_ACC_ADDR 3'h4
`define MODE_CODE_READ 3'h3
`define MODE_CODE_SHIFT_OUT 3'h2
`define MODE_CODE_WRITE 3'h1
`define MODE_CODE_ACC_DATA 3'h0

// ---------------------------------------------------------------
// array shape
// ---------------------------------------------------------------
`define WORD_COUNT 100
`define WORD_WIDTH 14
`define DIGIT_WIDTH 10
`define ADDR_INDEX_WIDTH 7
`define DATA_RESET 14'h0000
`define ADDR_RESET 20'h00000

// ---------------------------------------------------------------
// timing, counted in pulses of the controller clock
// ---------------------------------------------------------------
`define LINK_CLK_NOM_HZ 14000
`define PROG_TIME_MIN_MS 16
`define PROG_PULSES ((`PROG_TIME_MIN_MS * `LINK_CLK_NOM_HZ + 999) / 1000)
`endif

// ==== rtl/eeprom_pkg.sv ====
package eeprom_pkg;
    // operating mode decoded from the three mode lines
    typedef enum logic [2:0] {
        MODE_STANDBY,
        MODE_ERASE,
        MODE_ACC_ADDR,
        MODE_READ,
        MODE_SHIFT_OUT,
        MODE_WRITE,
        MODE_ACC_DATA
    } mode_e;

    // erase / write sequencer
    typedef enum logic [1:0] {
        PROG_IDLE,
        PROG_RUN,
        PROG_DONE
    } prog_e;
endpackage : eeprom_pkg

// ==== rtl/serial_word_eeprom.sv ====
`timescale 1ns/1ps
`include "eeprom_defs.svh"

module serial_word_eeprom #(
    parameter int WORDS = `WORD_COUNT,
    parameter int WIDTH = `WORD_WIDTH,
    parameter int PROG_PULSES = `PROG_PULSES
) (
    // core clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    // controller clock and mode lines (asynchronous pins)
    input wire logic LINK_CLK_I,
    input wire logic MODE_SELECT_A_I,
    input wire logic MODE_SELECT_B_I,
    input wire logic MODE_SELECT_C_I,
    // bidirectional data pin, split
    input wire logic DATA_I,
    output logic DATA_O,
    output logic DATA_OE_O,
    // programming in progress
    output logic PROG_BUSY_O
);

    // ---------------------------------------------------------------
    // local sizes
    // ---------------------------------------------------------------
    localparam int ADDR_BITS = 2 * `DIGIT_WIDTH;
    localparam int CNT_W = $clog2(PROG_PULSES + 1);
    localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_PULSES);

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    // one-of-ten digit to binary; 4'hF marks a bad code
    function automatic logic [3:0] digit_decode(input logic [`DIGIT_WIDTH-1:0] code);
        logic [3:0] val;
        val = 4'hF;
        for (int i = 0; i < `DIGIT_WIDTH; i++) begin
            if (code == (`DIGIT_WIDTH'(1) << i)) begin
                val = 4'(i);
            end
        end
        return val;
    endfunction : digit_decode

    // pin code to mode; the unused code falls back to standby
    function automatic eeprom_pkg::mode_e mode_decode(input logic [2:0] code);
        eeprom_pkg::mode_e m;
        m = eeprom_pkg::MODE_STANDBY;
        case (code)
            `MODE_CODE_ERASE: m = eeprom_pkg::MODE_ERASE;
            `MODE_CODE_ACC_ADDR: m = eeprom_pkg::MODE_ACC_ADDR;
            `MODE_CODE_READ: m = eeprom_pkg::MODE_READ;
            `MODE_CODE_SHIFT_OUT: m = eeprom_pkg::MODE_SHIFT_OUT;
            `MODE_CODE_WRITE: m = eeprom_pkg::MODE_WRITE;
            `MODE_CODE_ACC_DATA: m = eeprom_pkg::MODE_ACC_DATA;
            default: m = eeprom_pkg::MODE_STANDBY; // RULE_17
        endcase
        return m;
    endfunction : mode_decode

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] mode_meta_reg;
    logic [2:0] mode_sync_reg;
    logic clk_meta_reg;
    logic clk_sync_reg;
    logic clk_prev_reg;
    logic data_meta_reg;
    logic data_sync_reg;

    // all pins share one depth so clock and data stay aligned
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            mode_meta_reg <= `MODE_CODE_STANDBY;
            mode_sync_reg <= `MODE_CODE_STANDBY;
            clk_meta_reg <= 1'b1;
            clk_sync_reg <= 1'b1;
            clk_prev_reg <= 1'b1;
            data_meta_reg <= 1'b0;
            data_sync_reg <= 1'b0;
        end else begin
            mode_meta_reg <= {MODE_SELECT_A_I, MODE_SELECT_B_I, MODE_SELECT_C_I};
            mode_sync_reg <= mode_meta_reg;
            clk_meta_reg <= LINK_CLK_I;
            clk_sync_reg <= clk_meta_reg;
            clk_prev_reg <= clk_sync_reg;
            data_meta_reg <= DATA_I;
            data_sync_reg <= data_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // mode and clock pulse
    // ---------------------------------------------------------------
    eeprom_pkg::mode_e mode;
    logic clk_rise;

    // a pulse is the rising edge of the controller clock; a parked
    // high clock therefore gives no pulse at all
    assign mode = mode_decode(mode_sync_reg); // RULE_01
    assign clk_rise = clk_sync_reg & ~clk_prev_reg;

    // ---------------------------------------------------------------
    // address registers
    // ---------------------------------------------------------------
    logic [ADDR_BITS-1:0] addr_reg;
    logic [ADDR_BITS-1:0] addr_next;
    logic [3:0] tens_digit;
    logic [3:0] units_digit;
    logic addr_valid;
    logic [`ADDR_INDEX_WIDTH-1:0] tens_scaled;
    logic [`ADDR_INDEX_WIDTH-1:0] word_index;

    // new bits enter at the top, so after twenty pulses the first
    // digit sent (tens) sits in the low half
    always_comb begin
        addr_next = addr_reg;
        if (mode == eeprom_pkg::MODE_ACC_ADDR && clk_rise) begin // RULE_04
            addr_next = {data_sync_reg, addr_reg[ADDR_BITS-1:1]}; // RULE_16
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            addr_reg <= `ADDR_RESET;
        end else begin
            addr_reg <= addr_next; // RULE_02
        end
    end

    // bad digit codes select no word at all
    assign tens_digit = digit_decode(addr_reg[`DIGIT_WIDTH-1:0]); // RULE_05
    assign units_digit = digit_decode(addr_reg[ADDR_BITS-1:`DIGIT_WIDTH]); // RULE_05
    assign addr_valid = (tens_digit != 4'hF) && (units_digit != 4'hF);
    // both factors widened first so the product is never cut to four bits;
    // a bad tens digit wraps the index and a bad units digit skews it; addr_valid masks both off
    assign tens_scaled = `ADDR_INDEX_WIDTH'(tens_digit) * `ADDR_INDEX_WIDTH'(4'hA);
    assign word_index = tens_scaled + `ADDR_INDEX_WIDTH'(units_digit);

    // ---------------------------------------------------------------
    // memory array
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] mem_reg [WORDS];
    logic [WIDTH-1:0] read_word;
    // data register is declared here because the array update reads it
    logic [WIDTH-1:0] data_reg;
    logic [WIDTH-1:0] data_next;

    // an invalid address reads as all low
    assign read_word = addr_valid ? mem_reg[word_index] : `DATA_RESET; // RULE_06

    // ---------------------------------------------------------------
    // erase / write sequencer
    // ---------------------------------------------------------------
    eeprom_pkg::prog_e prog_reg;
    eeprom_pkg::prog_e prog_next;
    logic [CNT_W-1:0] pulse_cnt_reg;
    logic prog_mode;
    logic prog_commit;
    eeprom_pkg::mode_e mode_prev_reg;
    logic mode_changed;

    // a direct step from erase to write is a new hold and must restart
    // the count; otherwise the second operation would sit in the done
    // state and never commit
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            mode_prev_reg <= eeprom_pkg::MODE_STANDBY;
        end else begin
            mode_prev_reg <= mode;
        end
    end

    assign mode_changed = (mode != mode_prev_reg);

    assign prog_mode = (mode == eeprom_pkg::MODE_ERASE) || (mode == eeprom_pkg::MODE_WRITE);
    assign prog_commit = (prog_reg == eeprom_pkg::PROG_RUN) && clk_rise && (pulse_cnt_reg == PROG_LAST);

    // the cell is changed once, after the least program time has been
    // counted in controller pulses; a shorter hold leaves it untouched
    always_comb begin
        prog_next = prog_reg;
        case (prog_reg)
            eeprom_pkg::PROG_IDLE: begin
                if (prog_mode) begin
                    prog_next = eeprom_pkg::PROG_RUN;
                end
            end
            eeprom_pkg::PROG_RUN: begin
                if (!prog_mode || mode_changed) begin
                    prog_next = eeprom_pkg::PROG_IDLE;
                end else if (prog_commit) begin
                    prog_next = eeprom_pkg::PROG_DONE;
                end
            end
            // one idle cycle between two holds lets the counter reload
            eeprom_pkg::PROG_DONE: begin
                if (!prog_mode || mode_changed) begin
                    prog_next = eeprom_pkg::PROG_IDLE;
                end
            end
            default: prog_next = eeprom_pkg::PROG_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            prog_reg <= eeprom_pkg::PROG_IDLE;
        end else begin
            prog_reg <= prog_next;
        end
    end

    // pulse counter restarts on every new erase or write hold
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            pulse_cnt_reg <= '0;
        end else if (prog_reg != eeprom_pkg::PROG_RUN) begin
            pulse_cnt_reg <= CNT_W'(1);
        end else if (clk_rise && pulse_cnt_reg != PROG_LAST) begin
            pulse_cnt_reg <= pulse_cnt_reg + CNT_W'(1);
        end
    end

    // array update; write only sets bits, so a word is erased first
    always_ff @(posedge CORE_CLK_I) begin
        if (prog_commit && addr_valid && mode == eeprom_pkg::MODE_ERASE) begin
            mem_reg[word_index] <= `DATA_RESET; // RULE_03
        end else if (prog_commit && addr_valid && mode == eeprom_pkg::MODE_WRITE) begin
            mem_reg[word_index] <= mem_reg[word_index] | data_reg; // RULE_09
        end
    end

    assign PROG_BUSY_O = (prog_reg == eeprom_pkg::PROG_RUN);

    // ---------------------------------------------------------------
    // data register
    // ---------------------------------------------------------------
    // shift-out moves right with zero fill, so a second pass reads zeros
    // read copies on every core cycle, so a short read hold is enough
    always_comb begin
        data_next = data_reg;
        case (mode)
            eeprom_pkg::MODE_READ: begin
                data_next = read_word; // RULE_07
            end
            eeprom_pkg::MODE_ACC_DATA: begin
                if (clk_rise) begin
                    data_next = {data_sync_reg, data_reg[WIDTH-1:1]}; // RULE_10
                end
            end
            eeprom_pkg::MODE_SHIFT_OUT: begin
                if (clk_rise) begin
                    data_next = {1'b0, data_reg[WIDTH-1:1]}; // RULE_08
                end
            end
            default: data_next = data_reg; // RULE_02
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            data_reg <= `DATA_RESET;
        end else begin
            data_reg <= data_next;
        end
    end

    // ---------------------------------------------------------------
    // pin driver
    // ---------------------------------------------------------------
    // registered so the pin never glitches on a mode decode; taken from
    // data_next so bit0 shows on the same edge as the enable
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            DATA_O <= 1'b0;
        end else begin
            DATA_O <= data_next[0]; // RULE_08
        end
    end

    // enable follows the synchronised mode only, so it changes on a
    // clean core edge; the controller sees it a few core cycles late
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            DATA_OE_O <= 1'b0;
        end else begin
            DATA_OE_O <= (mode == eeprom_pkg::MODE_SHIFT_OUT); // RULE_11
        end
    end

endmodule : serial_word_eeprom

// ==== test/ctrl_model.sv ====
`timescale 1ns/1ps
`include "eeprom_defs.svh"
module ctrl_model (
    // core clock and pin level
    input wire logic clk_i,
    input wire logic pin_i,
    // lines to the device
    output logic link_clk_o,
    output logic [2:0] mode_o,
    output logic dat_o
);
    logic [3:0] cnt = 4'h0;
    // 16 cycle stand-in for the slow clock, parked high in standby only
    always @(posedge clk_i) begin
        cnt <= cnt + 4'h1;
        link_clk_o <= mode_o == `MODE_CODE_STANDBY ? 1'b1 : cnt[3];
    end
    // quiet lines at time zero
    initial begin
        link_clk_o = 1'b1;
        mode_o = `MODE_CODE_STANDBY;
        dat_o = 1'b0;
    end
    // change mode just after a rise, so no stray pulse lands in the new mode
    task automatic set_mode(input logic [2:0] m);
        @(posedge clk_i iff cnt == 4'hC);
        mode_o <= m;
    endtask : set_mode
    // n bits lsb first, each settled long before its rise
    task automatic send(input logic [19:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i iff cnt == 4'h2);
            dat_o <= v[i];
        end
    endtask : send
    // released line shows the inverse, so a floating pin reads one level and fails any mixed word
    task automatic get(output logic [13:0] v);
        dat_o <= ~dat_o;
        for (int i = 0; i < 14; i++) begin
            @(posedge clk_i iff cnt == 4'h6);
            v[i] = pin_i;
        end
    endtask : get
    // stay in the present mode for n pulses
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i iff cnt == 4'hC);
    endtask : hold
endmodule : ctrl_model

// ==== test/serial_word_eeprom_chk.sv ====
`timescale 1ns/1ps
`include "eeprom_defs.svh"
module serial_word_eeprom_chk (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    // controller pins
    input wire logic LINK_CLK_I,
    input wire logic MODE_SELECT_A_I,
    input wire logic MODE_SELECT_B_I,
    input wire logic MODE_SELECT_C_I,
    // device outputs
    input wire logic DATA_O,
    input wire logic DATA_OE_O,
    input wire logic PROG_BUSY_O
);
    // raw pin code; the pins are async, so every check leaves room for the sync delay
    wire logic [2:0] mode = {MODE_SELECT_A_I, MODE_SELECT_B_I, MODE_SELECT_C_I};
    wire logic prog = mode == `MODE_CODE_ERASE || mode == `MODE_CODE_WRITE;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);
    property p_oe_idle;
        (mode != `MODE_CODE_SHIFT_OUT)[*6] |-> !DATA_OE_O;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("pin driven off shift-out");
    property p_oe_on;
        (mode == `MODE_CODE_SHIFT_OUT)[*6] |-> DATA_OE_O;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("pin not driven in shift-out");
    property p_oe_cause;
        $rose(DATA_OE_O) |-> $past(mode, 2) == `MODE_CODE_SHIFT_OUT;
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("driver on without shift-out");
    property p_out_hold;
        (DATA_OE_O && !LINK_CLK_I)[*6] |-> $stable(DATA_O);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("pin moved without pulse");
    property p_reset_quiet;
        $fell(RESET_I) |-> !DATA_OE_O && !DATA_O && !PROG_BUSY_O;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
    property p_busy_cause;
        $rose(PROG_BUSY_O) |-> $past(prog, 2);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without erase or write");
    property p_busy_hold;
        $rose(PROG_BUSY_O) |-> PROG_BUSY_O[*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
    property p_busy_ends;
        PROG_BUSY_O && !prog |-> ##[1:6] !PROG_BUSY_O;
    endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("busy stuck after mode left");
endmodule : serial_word_eeprom_chk
bind serial_word_eeprom serial_word_eeprom_chk i_serial_word_eeprom_chk (.CORE_CLK_I(CORE_CLK_I),
    .RESET_I(RESET_I), .LINK_CLK_I(LINK_CLK_I), .MODE_SELECT_A_I(MODE_SELECT_A_I),
    .MODE_SELECT_B_I(MODE_SELECT_B_I), .MODE_SELECT_C_I(MODE_SELECT_C_I), .DATA_O(DATA_O),
    .DATA_OE_O(DATA_OE_O), .PROG_BUSY_O(PROG_BUSY_O));

// ==== test/serial_word_eeprom_tb.sv ====
`timescale 1ns/1ps
`include "eeprom_defs.svh"
module serial_word_eeprom_tb;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic link_clk;
    logic dat;
    logic [2:0] mode;
    logic data_out;
    logic data_oe;
    logic busy;
    logic [13:0] got;
    int n_mismatch = 0;
    int n_tests = 0;
    // pin level: device wins only while its driver is on
    wire logic pin = data_oe ? data_out : dat;
    // 200 MHz core clock
    always #2.5 core_clk = ~core_clk;
    // short programming count keeps each hold brief
    serial_word_eeprom #(.PROG_PULSES(4)) i_serial_word_eeprom (.CORE_CLK_I(core_clk), .RESET_I(reset),
        .LINK_CLK_I(link_clk), .MODE_SELECT_A_I(mode[2]), .MODE_SELECT_B_I(mode[1]), .MODE_SELECT_C_I(mode[0]),
        .DATA_I(pin), .DATA_O(data_out), .DATA_OE_O(data_oe), .PROG_BUSY_O(busy));
    ctrl_model i_ctrl_model (.clk_i(core_clk), .pin_i(pin), .link_clk_o(link_clk), .mode_o(mode), .dat_o(dat));
    task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // tens digit then units digit, each one-hot
    task automatic put_addr(input int t, input int u);
        i_ctrl_model.set_mode(`MODE_CODE_ACC_ADDR);
        i_ctrl_model.send({10'h001 << u, 10'h001 << t}, 20);
    endtask : put_addr
    task automatic put_data(input logic [13:0] v);
        i_ctrl_model.set_mode(`MODE_CODE_ACC_DATA);
        i_ctrl_model.send({6'h00, v}, 14);
    endtask : put_data
    // erase or write held n pulses; busy must show after the second
    task automatic prog(input logic [2:0] m, input int n);
        i_ctrl_model.set_mode(m);
        i_ctrl_model.hold(2);
        check("busy", {13'h0000, busy}, 14'h0001);
        i_ctrl_model.hold(n - 2);
    endtask : prog
    // load the word, then shift it out on the pin
    task automatic read_out(input logic [13:0] exp);
        i_ctrl_model.set_mode(`MODE_CODE_READ);
        i_ctrl_model.hold(1);
        check("float", {13'h0000, data_oe}, 14'h0000);
        i_ctrl_model.set_mode(`MODE_CODE_SHIFT_OUT);
        i_ctrl_model.get(got);
        check("word", got, exp);
        i_ctrl_model.set_mode(`MODE_CODE_STANDBY);
    endtask : read_out
    // hang guard: the sequence needs about 20 us
    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        check("oe", {13'h0000, data_oe}, 14'h0000);
        // word 99: erase, write, read back with the top bit set
        put_addr(9, 9);
        put_data(14'h2A5C);
        prog(`MODE_CODE_ERASE, 5);
        prog(`MODE_CODE_WRITE, 5);
        read_out(14'h2A5C);
        // word 00: all ones, then erased back to zero
        put_addr(0, 0);
        put_data(14'h3FFF);
        prog(`MODE_CODE_ERASE, 5);
        prog(`MODE_CODE_WRITE, 5);
        prog(`MODE_CODE_ERASE, 5);
        read_out(14'h0000);
        // a data load must leave the address on word 00
        put_data(14'h1573);
        prog(`MODE_CODE_WRITE, 5);
        put_data(14'h0AC1);
        read_out(14'h1573);
        // too short an erase leaves word 99 as it was
        put_addr(9, 9);
        prog(`MODE_CODE_ERASE, 2);
        read_out(14'h2A5C);
        // unused code and standby keep the data register, pin floats
        i_ctrl_model.set_mode(`MODE_CODE_READ);
        i_ctrl_model.set_mode(`MODE_CODE_UNUSED);
        i_ctrl_model.hold(3);
        check("oe", {13'h0000, data_oe}, 14'h0000);
        i_ctrl_model.set_mode(`MODE_CODE_STANDBY);
        i_ctrl_model.hold(3);
        check("oe", {13'h0000, data_oe}, 14'h0000);
        i_ctrl_model.set_mode(`MODE_CODE_SHIFT_OUT);
        i_ctrl_model.get(got);
        check("kept", got, 14'h2A5C);
        final_report();
    end
endmodule : serial_word_eeprom_tb
